/* rtl/umf_fragmenter.sv */
// Overview of operation
// - Partial grant on enabled flow starts fragmenting
// - Concatenated frame split as one unit
// - Fill partial grant with largest fitting payload
// - Piggyback when no later grant or pending
// - Next-fragment request in fragment header; next frame last
// - Never place one request twice
// - Request remainder plus 16 bytes plus PHY; first request is whole frame plus PHY only
// - Ack timeout: back off and re-request remainder
// - Retry limit exceeded discards untransmitted part
// - First, middle, last flag encoding
// - Sequence number increments per fragment
// - Encrypt per fragment, after header check
// - No fragmenting in request/data regions
// - Multi-grant: MAP without grant or pending forces re-request
// - Grant with pending: no piggyback request
// - Modem tracks remainder itself
//
// Implementation choices: the Avalon-MM register port and the address map.
`timescale 1ns/1ps
`default_nettype none
`include "umf_map.svh"
module umf_fragmenter
  import umf_pkg::*;
#(
  parameter int DEPTH = 2048
)
(
  input wire logic clk,
  input wire logic rst,
  input wire logic [2:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic frm_valid,
  input wire logic [7:0] frm_data,
  input wire logic frm_last,
  output logic frm_ready,
  input wire logic next_len_valid,
  input wire logic [15:0] next_len,
  input wire umf_map_type map_in,
  input wire umf_grant_type grant_in,
  output logic req_valid,
  output logic [15:0] req_slots,
  output logic desc_valid,
  output umf_desc_type desc,
  output logic pay_valid,
  output logic [7:0] pay_data,
  output logic pay_last,
  input wire logic pay_ready
);
  localparam int AW = $clog2(DEPTH);
  generate
    if (DEPTH < 16 || DEPTH > 65535)
    begin : g_bad_depth
      $error("DEPTH must lie between 16 and 65535");
    end
  endgenerate

  function automatic logic [15:0] slots_for(input logic [23:0] bytes, input logic [7:0] bps);
    logic [23:0] div;
    logic [23:0] q;
    div = (bps == 8'h00) ? 24'h000001 : {16'h0000, bps};
    q = (bytes + div - 24'h000001) / div;
    slots_for = (q > 24'h00ffff) ? 16'hffff : q[15:0];
  endfunction

  function automatic logic [7:0] piggy_sat(input logic [15:0] slots);
    piggy_sat = (slots > 16'h00ff) ? 8'hff : slots[7:0];
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Register file
  logic [2:0] ctrl_q, ctrl_d;
  logic [7:0] bps_q, bps_d, poh_q, poh_d;
  logic [15:0] ack_q, ack_d, backoff_q, backoff_d;
  logic [3:0] limit_q, limit_d;
  logic wait_q, wait_d;
  logic [31:0] rdata_q, rdata_d;
  logic [15:0] discards_q, discards_d, frags_q, frags_d;
  umf_state_type state_q, state_d;
  logic [15:0] remain_q, remain_d;
  logic [3:0] seq_q, seq_d, retries_q, retries_d;
  logic frag_q, frag_d;
  logic wr_go;
  assign wr_go = avs_write && !wait_q;

  always_comb
  begin
    ctrl_d = ctrl_q;
    bps_d = bps_q;
    poh_d = poh_q;
    ack_d = ack_q;
    limit_d = limit_q;
    backoff_d = backoff_q;
    wait_d = !((avs_read || avs_write) && wait_q);
    rdata_d = rdata_q;
    if (avs_read && wait_q)
    begin
      case (avs_address)
        `UMF_REG_CTRL: rdata_d = {29'h0, ctrl_q};
        `UMF_REG_SLOT_BYTES: rdata_d = {24'h0, bps_q};
        `UMF_REG_PHY_OVH: rdata_d = {24'h0, poh_q};
        `UMF_REG_ACK_TIME: rdata_d = {16'h0, ack_q};
        `UMF_REG_RETRY_LIMIT: rdata_d = {28'h0, limit_q};
        `UMF_REG_BACKOFF: rdata_d = {16'h0, backoff_q};
        `UMF_REG_STATUS: rdata_d = {state_q, frag_q, retries_q, seq_q, 4'h0, remain_q};
        `UMF_REG_COUNTS: rdata_d = {frags_q, discards_q};
        default: rdata_d = 32'h0;
      endcase
    end
    if (wr_go)
    begin
      case (avs_address)
        `UMF_REG_CTRL: ctrl_d = avs_writedata[2:0];
        `UMF_REG_SLOT_BYTES: bps_d = avs_writedata[7:0];
        `UMF_REG_PHY_OVH: poh_d = avs_writedata[7:0];
        `UMF_REG_ACK_TIME: ack_d = avs_writedata[15:0];
        `UMF_REG_RETRY_LIMIT: limit_d = avs_writedata[3:0];
        `UMF_REG_BACKOFF: backoff_d = avs_writedata[15:0];
        default: ctrl_d = ctrl_q;
      endcase
    end
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      ctrl_q <= `UMF_RST_CTRL;
      bps_q <= `UMF_RST_SLOT_BYTES;
      poh_q <= `UMF_RST_PHY_OVH;
      ack_q <= `UMF_RST_ACK_TIME;
      limit_q <= `UMF_RST_RETRY_LIMIT;
      backoff_q <= `UMF_RST_BACKOFF;
      wait_q <= 1'b1;
      rdata_q <= 32'h0;
    end
    else
    begin
      ctrl_q <= ctrl_d;
      bps_q <= bps_d;
      poh_q <= poh_d;
      ack_q <= ack_d;
      limit_q <= limit_d;
      backoff_q <= backoff_d;
      wait_q <= wait_d;
      rdata_q <= rdata_d;
    end
  end
  assign avs_waitrequest = wait_q;
  assign avs_readdata = rdata_q;

  ////////////////////////////////////////////////////////////////////////////
  // Frame store
  logic [AW-1:0] raddr;
  logic [7:0] rdata;
  logic we;
  logic [15:0] wr_ptr_q, wr_ptr_d, len_q, len_d, base_q, base_d, cnt_q, cnt_d;
  logic loaded_q, loaded_d, in_ready_q, in_ready_d;

  umf_frame_ram #(.WIDTH(8), .DEPTH(DEPTH), .AW(AW)) u_ram (
    .clk(clk),
    .rst(rst),
    .we(we),
    .waddr(wr_ptr_q[AW-1:0]),
    .wdata(frm_data),
    .raddr(raddr),
    .rdata(rdata)
  );
  // Whole frame, single or concatenated, stored as one byte run
  assign we = frm_valid && in_ready_q;

  ////////////////////////////////////////////////////////////////////////////
  // Fragmentation engine
  logic [15:0] timer_q, timer_d;
  logic armed_q, armed_d, mg_q, mg_d, next_req_q, next_req_d, rd_pend_q, rd_pend_d;
  logic req_valid_q, req_valid_d, desc_valid_q, desc_valid_d;
  logic [15:0] req_slots_q, req_slots_d;
  umf_desc_type desc_q, desc_d;
  logic pay_valid_q, pay_valid_d, pay_last_q, pay_last_d;
  logic [7:0] pay_data_q, pay_data_d;
  logic [23:0] gnt_bytes, avail, need, plen, rem_after;
  logic frag_en, fits, can_frag;

  always_comb
  begin
    gnt_bytes = {8'h00, grant_in.slots} * {16'h0000, bps_q};
    avail = (gnt_bytes > {16'h0000, poh_q}) ? gnt_bytes - {16'h0000, poh_q} : 24'h0;
    need = {8'h00, remain_q} + (frag_q ? `UMF_FRAG_OVH : 24'h0);
    // Modem and flow enables come from the CTRL register bits
    frag_en = ctrl_q[`UMF_CTRL_MODEM_EN] && ctrl_q[`UMF_CTRL_FLOW_EN];
    fits = avail >= need;
    can_frag = frag_en && !grant_in.immediate && (avail > `UMF_FRAG_OVH);
    plen = (fits || !can_frag) ? {8'h00, remain_q} : avail - `UMF_FRAG_OVH;
    rem_after = {8'h00, remain_q} - plen;
  end

  always_comb
  begin
    state_d = state_q;
    remain_d = remain_q;
    seq_d = seq_q;
    retries_d = retries_q;
    frag_d = frag_q;
    timer_d = timer_q;
    armed_d = armed_q;
    mg_d = mg_q;
    next_req_d = next_req_q;
    wr_ptr_d = wr_ptr_q;
    len_d = len_q;
    base_d = base_q;
    cnt_d = cnt_q;
    loaded_d = loaded_q;
    in_ready_d = in_ready_q;
    rd_pend_d = 1'b0;
    raddr = base_q[AW-1:0];
    req_valid_d = 1'b0;
    req_slots_d = req_slots_q;
    desc_valid_d = 1'b0;
    desc_d = desc_q;
    pay_valid_d = pay_valid_q && !pay_ready;
    pay_last_d = pay_last_q;
    pay_data_d = pay_data_q;
    discards_d = discards_q;
    frags_d = frags_q;
    if (armed_q && timer_q != 16'h0)
    begin
      timer_d = timer_q - 16'h0001;
    end
    case (state_q)
      UMF_IDLE:
      begin
        in_ready_d = !loaded_q && !(we && frm_last) && (wr_ptr_q < 16'(DEPTH - 1));
        if (we)
        begin
          wr_ptr_d = wr_ptr_q + 16'h0001;
          if (frm_last)
          begin
            loaded_d = 1'b1;
            len_d = wr_ptr_q + 16'h0001;
          end
        end
        if (loaded_q)
        begin
          remain_d = len_q;
          base_d = 16'h0;
          frag_d = 1'b0;
          seq_d = 4'h0;
          retries_d = 4'h0;
          mg_d = 1'b0;
          // Already requested in the previous frame's last fragment
          state_d = next_req_q ? UMF_WAIT : UMF_REQ;
          next_req_d = 1'b0;
          armed_d = next_req_q;
          timer_d = ack_q;
        end
      end
      UMF_REQ:
      begin
        req_valid_d = 1'b1;
        req_slots_d = slots_for(need + {16'h0000, poh_q}, bps_q);
        timer_d = ack_q;
        armed_d = 1'b1;
        mg_d = 1'b0;
        state_d = UMF_WAIT;
      end
      UMF_WAIT:
      begin
        if (grant_in.valid && grant_in.slots != 16'h0)
        begin
          armed_d = 1'b0;
          retries_d = 4'h0;
          desc_d.fragmented = frag_q || !fits && can_frag;
          desc_d.first = !frag_q && !fits && can_frag;
          desc_d.last = frag_q && (fits || !can_frag);
          desc_d.encrypt = ctrl_q[`UMF_CTRL_PRIVACY];
          desc_d.seq = seq_q;
          desc_d.offset = base_q;
          desc_d.len = plen[15:0];
          desc_d.piggy = 8'h00;
          if (grant_in.more)
          begin
            // Pending or later grant: piggyback stays zero
            mg_d = rem_after != 24'h0;
          end
          else if (rem_after != 24'h0)
          begin
            desc_d.piggy = piggy_sat(slots_for(rem_after + `UMF_FRAG_OVH +
              {16'h0000, poh_q}, bps_q));
            mg_d = 1'b0;
          end
          else if (next_len_valid)
          begin
            desc_d.piggy = piggy_sat(slots_for({8'h00, next_len} +
              {16'h0000, poh_q}, bps_q));
            next_req_d = 1'b1;
          end
          frag_d = frag_q || !fits && can_frag;
          remain_d = rem_after[15:0];
          cnt_d = plen[15:0];
          state_d = UMF_DESC;
        end
        else if (map_in.valid && (map_in.has_grant || map_in.has_pending))
        begin
          armed_d = 1'b0;
          mg_d = 1'b1;
        end
        else if (map_in.valid && mg_q)
        begin
          state_d = UMF_REQ;
        end
        else if (armed_q && timer_q == 16'h0)
        begin
          armed_d = 1'b0;
          if (retries_q >= limit_q)
          begin
            state_d = UMF_DROP;
          end
          else
          begin
            retries_d = retries_q + 4'h1;
            timer_d = backoff_q << retries_q;
            state_d = UMF_BACKOFF;
          end
        end
      end
      UMF_BACKOFF:
      begin
        if (timer_q == 16'h0)
        begin
          state_d = UMF_REQ;
        end
        else
        begin
          timer_d = timer_q - 16'h0001;
        end
      end
      UMF_DESC:
      begin
        desc_valid_d = 1'b1;
        if (desc_q.fragmented)
        begin
          seq_d = seq_q + 4'h1;
          frags_d = frags_q + 16'h0001;
        end
        state_d = UMF_SEND;
      end
      UMF_SEND:
      begin
        if (rd_pend_q)
        begin
          pay_valid_d = 1'b1;
          pay_data_d = rdata;
          pay_last_d = cnt_q == 16'h0;
        end
        else if (cnt_q != 16'h0 && (!pay_valid_q || pay_ready))
        begin
          raddr = base_q[AW-1:0];
          base_d = base_q + 16'h0001;
          cnt_d = cnt_q - 16'h0001;
          rd_pend_d = 1'b1;
        end
        else if (cnt_q == 16'h0 && (!pay_valid_q || pay_ready))
        begin
          if (remain_q == 16'h0)
          begin
            loaded_d = 1'b0;
            wr_ptr_d = 16'h0;
            in_ready_d = 1'b1;
            state_d = UMF_IDLE;
          end
          else
          begin
            // Piggyback sent arms the ack timer; multi-grant waits on MAPs
            armed_d = !mg_q;
            timer_d = ack_q;
            state_d = UMF_WAIT;
          end
        end
      end
      UMF_DROP:
      begin
        // Untransmitted remainder is abandoned
        remain_d = 16'h0;
        discards_d = discards_q + 16'h0001;
        loaded_d = 1'b0;
        wr_ptr_d = 16'h0;
        in_ready_d = 1'b1;
        next_req_d = 1'b0;
        state_d = UMF_IDLE;
      end
      default:
      begin
        state_d = UMF_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      state_q <= UMF_IDLE;
      remain_q <= 16'h0;
      seq_q <= 4'h0;
      retries_q <= 4'h0;
      frag_q <= 1'b0;
      timer_q <= 16'h0;
      armed_q <= 1'b0;
      mg_q <= 1'b0;
      next_req_q <= 1'b0;
      wr_ptr_q <= 16'h0;
      len_q <= 16'h0;
      base_q <= 16'h0;
      cnt_q <= 16'h0;
      loaded_q <= 1'b0;
      in_ready_q <= 1'b0;
      rd_pend_q <= 1'b0;
      req_valid_q <= 1'b0;
      req_slots_q <= 16'h0;
      desc_valid_q <= 1'b0;
      desc_q <= '0;
      pay_valid_q <= 1'b0;
      pay_last_q <= 1'b0;
      pay_data_q <= 8'h00;
      discards_q <= 16'h0;
      frags_q <= 16'h0;
    end
    else
    begin
      state_q <= state_d;
      remain_q <= remain_d;
      seq_q <= seq_d;
      retries_q <= retries_d;
      frag_q <= frag_d;
      timer_q <= timer_d;
      armed_q <= armed_d;
      mg_q <= mg_d;
      next_req_q <= next_req_d;
      wr_ptr_q <= wr_ptr_d;
      len_q <= len_d;
      base_q <= base_d;
      cnt_q <= cnt_d;
      loaded_q <= loaded_d;
      in_ready_q <= in_ready_d;
      rd_pend_q <= rd_pend_d;
      req_valid_q <= req_valid_d;
      req_slots_q <= req_slots_d;
      desc_valid_q <= desc_valid_d;
      desc_q <= desc_d;
      pay_valid_q <= pay_valid_d;
      pay_last_q <= pay_last_d;
      pay_data_q <= pay_data_d;
      discards_q <= discards_d;
      frags_q <= frags_d;
    end
  end

  assign frm_ready = in_ready_q;
  assign req_valid = req_valid_q;
  assign req_slots = req_slots_q;
  assign desc_valid = desc_valid_q;
  assign desc = desc_q;
  assign pay_valid = pay_valid_q;
  assign pay_data = pay_data_q;
  assign pay_last = pay_last_q;
endmodule
`default_nettype wire

/* rtl/umf_frame_ram.sv */
`timescale 1ns/1ps
`default_nettype none
module umf_frame_ram
  import umf_pkg::*;
#(
  parameter int WIDTH = 8,
  parameter int DEPTH = 2048,
  parameter int AW = $clog2(DEPTH)
)
(
  input wire logic clk,
  input wire logic rst,
  input wire logic we,
  input wire logic [AW-1:0] waddr,
  input wire logic [WIDTH-1:0] wdata,
  input wire logic [AW-1:0] raddr,
  output logic [WIDTH-1:0] rdata
);
  logic [WIDTH-1:0] mem [DEPTH];
  always_ff @(posedge clk)
  begin
    if (we)
    begin
      mem[waddr] <= wdata;
    end
  end
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      rdata <= '0;
    end
    else
    begin
      rdata <= mem[raddr];
    end
  end
endmodule
`default_nettype wire

/* rtl/umf_map.svh */
`ifndef UMF_MAP_SVH
`define UMF_MAP_SVH
// Register word indices (byte offset is four times the index)
`define UMF_REG_CTRL 3'h0
`define UMF_REG_SLOT_BYTES 3'h1
`define UMF_REG_PHY_OVH 3'h2
`define UMF_REG_ACK_TIME 3'h3
`define UMF_REG_RETRY_LIMIT 3'h4
`define UMF_REG_BACKOFF 3'h5
`define UMF_REG_STATUS 3'h6
`define UMF_REG_COUNTS 3'h7
// Control field positions
`define UMF_CTRL_MODEM_EN 0
`define UMF_CTRL_FLOW_EN 1
`define UMF_CTRL_PRIVACY 2
// Reset values
`define UMF_RST_CTRL 3'h0
`define UMF_RST_SLOT_BYTES 8'h10
`define UMF_RST_PHY_OVH 8'h20
`define UMF_RST_ACK_TIME 16'h07d0
`define UMF_RST_RETRY_LIMIT 4'h3
`define UMF_RST_BACKOFF 16'h0040
// Fragment overhead: header, header check and fragment CRC, in bytes
`define UMF_FRAG_OVH 24'h000010
`endif

/* rtl/umf_pkg.sv */
package umf_pkg;
  typedef enum logic [2:0] {
    UMF_IDLE,
    UMF_REQ,
    UMF_WAIT,
    UMF_BACKOFF,
    UMF_DESC,
    UMF_SEND,
    UMF_DROP
  } umf_state_type;
  typedef struct packed {
    logic fragmented;
    logic first;
    logic last;
    logic encrypt;
    logic [3:0] seq;
    logic [7:0] piggy;
    logic [15:0] offset;
    logic [15:0] len;
  } umf_desc_type;
  typedef struct packed {
    logic valid;
    logic has_grant;
    logic has_pending;
  } umf_map_type;
  typedef struct packed {
    logic valid;
    logic [15:0] slots;
    logic more;
    logic immediate;
  } umf_grant_type;
endpackage

/* verif/tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
`include "umf_map.svh"
module tb_top
  import umf_pkg::*;
;
  localparam int SLOT = 16;
  localparam int POH = 32;
  logic clk, rst, avs_read, avs_write, avs_waitrequest, frm_valid, frm_last, frm_ready;
  logic next_len_valid, req_valid, desc_valid, pay_valid, pay_last, pay_ready;
  logic he_multi, he_imm, he_mute;
  logic [2:0] avs_address;
  logic [31:0] avs_writedata, avs_readdata, rd;
  logic [31:0] rv [6];
  logic [7:0] frm_data, pay_data;
  logic [15:0] next_len, req_slots, he_max;
  umf_map_type map_in;
  umf_grant_type grant_in;
  umf_desc_type desc;
  umf_desc_type dq[$];
  logic [7:0] pq[$];
  logic [15:0] rq[$];
  int n_mismatch = 0;
  int tests_run = 0;
  umf_fragmenter uut (
    .clk, .rst, .avs_address, .avs_read, .avs_write, .avs_writedata, .avs_readdata,
    .avs_waitrequest, .frm_valid, .frm_data, .frm_last, .frm_ready, .next_len_valid,
    .next_len, .map_in, .grant_in, .req_valid, .req_slots, .desc_valid, .desc,
    .pay_valid, .pay_data, .pay_last, .pay_ready
  );
  umf_headend he (
    .clk, .rst, .req_valid, .req_slots, .desc_valid, .desc,
    .pay_done(pay_valid && pay_ready && pay_last), .max_slots(he_max),
    .multi(he_multi), .imm(he_imm), .mute(he_mute), .map_in, .grant_in
  );
  always #2.5 clk = ~clk;
  always @(posedge clk) pay_ready <= (pay_ready !== 1'b1);
  always @(posedge clk)
  begin
    if (desc_valid === 1'b1)
      dq.push_back(desc);
    if (pay_valid === 1'b1 && pay_ready)
      pq.push_back(pay_data);
    if (req_valid === 1'b1)
      rq.push_back(req_slots);
  end
  ////////////////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [47:0] s, x);
    tests_run++;
    if (s !== x)
    begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", nm, x, s);
    end
  endtask
  function automatic logic [15:0] slots(input int b);
    return 16'((b + POH + SLOT - 1) / SLOT);
  endfunction
  task automatic bus(input logic wr, input logic [2:0] a, input logic [31:0] d);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= wr;
    avs_read <= !wr;
    do
      @(posedge clk);
    while (avs_waitrequest !== 1'b0);
    rd = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    @(posedge clk);
  endtask
  task automatic run(input int len, input logic [15:0] mx, input logic mul, imm, cut);
    int n;
    dq.delete();
    pq.delete();
    rq.delete();
    he_max <= mx;
    he_multi <= mul;
    he_imm <= imm;
    he_mute <= 1'b0;
    for (int i = 0; i < len; i++)
    begin
      frm_valid <= 1'b1;
      frm_data <= 8'(i * 3 + 1);
      frm_last <= (i == len - 1);
      do
        @(posedge clk);
      while (frm_ready !== 1'b1);
    end
    frm_valid <= 1'b0;
    frm_last <= 1'b0;
    n = 0;
    while ((frm_ready !== 1'b1 || n < 4) && n < 3000)
    begin
      @(posedge clk);
      n++;
      if (cut && dq.size() > 0)
        he_mute <= 1'b1;
    end
    chk("frame done", n < 3000, 1'b1);
  endtask
  task automatic frags(input int len, input logic [15:0] mx, input logic mul, enc,
    input int nd);
    umf_desc_type e;
    int rem, pl, b;
    rem = len;
    b = mx * SLOT - POH;
    chk("descs", dq.size(), nd);
    for (int n = 0; n < nd && n < dq.size(); n++)
    begin
      pl = (b >= rem + (n > 0 ? 16 : 0)) ? rem : b - 16;
      e = '0;
      e.fragmented = 1'b1;
      e.first = (n == 0);
      e.last = (pl == rem);
      e.encrypt = enc;
      e.seq = 4'(n);
      e.offset = 16'(len - rem);
      e.len = 16'(pl);
      rem -= pl;
      if (!mul && rem > 0)
        e.piggy = 8'(slots(rem + 16));
      chk("desc", dq[n], e);
    end
    for (int i = 0; i < pq.size(); i++)
      chk("pay", pq[i], 8'(i * 3 + 1));
    chk("pay count", pq.size(), len - rem);
  endtask
  task automatic final_report();
    $display("Checks %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (20000) @(posedge clk);
    n_mismatch++;
    final_report();
  end
  initial
  begin
    clk = 1'b0;
    rst = 1'b1;
    {avs_read, avs_write, frm_valid, frm_last, next_len_valid} = '0;
    {he_multi, he_imm, he_mute, avs_address, avs_writedata, frm_data, next_len, he_max} = '0;
    rv = '{32'(`UMF_RST_CTRL), 32'(`UMF_RST_SLOT_BYTES), 32'(`UMF_RST_PHY_OVH),
      32'(`UMF_RST_ACK_TIME), 32'(`UMF_RST_RETRY_LIMIT), 32'(`UMF_RST_BACKOFF)};
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    foreach (rv[i])
    begin
      bus(1'b0, 3'(i), 32'h0);
      chk("reset value", rd, rv[i]);
    end
    bus(1'b1, `UMF_REG_ACK_TIME, 32'h14);
    bus(1'b1, `UMF_REG_BACKOFF, 32'h4);
    bus(1'b1, `UMF_REG_COUNTS, 32'hffffffff);
    bus(1'b0, `UMF_REG_COUNTS, 32'h0);
    chk("counts", rd, 32'h0);
    bus(1'b0, `UMF_REG_ACK_TIME, 32'h0);
    chk("ack time", rd, 32'h14);
    bus(1'b1, `UMF_REG_CTRL, 32'h3);
    run(40, 16'h4, 1'b0, 1'b0, 1'b0);
    chk("reqs", rq.size(), 1);
    chk("req", rq[0], slots(40));
    frags(40, 16'h4, 1'b0, 1'b0, 3);
    bus(1'b1, `UMF_REG_CTRL, 32'h7);
    next_len <= 16'h64;
    next_len_valid <= 1'b1;
    run(40, 16'h4, 1'b1, 1'b0, 1'b0);
    chk("reqs", rq.size(), 1);
    frags(40, 16'h4, 1'b1, 1'b1, 3);
    next_len_valid <= 1'b0;
    bus(1'b1, `UMF_REG_CTRL, 32'h3);
    run(40, 16'h4, 1'b0, 1'b1, 1'b0);
    chk("whole", dq[0], 48'd40);
    chk("pay count", pq.size(), 40);
    run(60, 16'h5, 1'b1, 1'b0, 1'b1);
    chk("reqs", rq.size(), 5);
    chk("req", rq[0], slots(60));
    chk("map rereq", rq[1], slots(28 + 16));
    chk("rereq", rq[4], slots(28 + 16));
    frags(60, 16'h5, 1'b1, 1'b0, 1);
    bus(1'b0, `UMF_REG_COUNTS, 32'h0);
    chk("counts", rd, {16'd7, 16'd1});
    final_report();
  end
endmodule
`default_nettype wire

/* verif/umf_fragmenter_sva.sv */
`timescale 1ns/1ps
`default_nettype none
module umf_fragmenter_sva
  import umf_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic avs_waitrequest,
  input wire umf_grant_type grant_in,
  input wire logic req_valid,
  input wire logic desc_valid,
  input wire umf_desc_type desc,
  input wire logic pay_valid,
  input wire logic pay_last,
  input wire logic pay_ready
);
  localparam int SLOT = 16;
  localparam int POH = 32;
  logic [3:0] seq_q;
  logic [15:0] end_q, cnt_q;
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  // Last descriptor and bytes streamed since it
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      seq_q <= '0;
      end_q <= '0;
      cnt_q <= '0;
    end
    else if (desc_valid)
    begin
      seq_q <= desc.seq;
      end_q <= desc.offset + desc.len;
      cnt_q <= '0;
    end
    else if (pay_valid && pay_ready)
      cnt_q <= cnt_q + 16'h1;
  end
  ////////////////////////////////////////////////////////////////////////
  property p_wait;
    (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest ##1 avs_waitrequest;
  endproperty
  a_wait: assert property (p_wait) else $error("bus answer not one cycle");
  property p_req;
    req_valid |=> !req_valid;
  endproperty
  a_req: assert property (p_req) else $error("request pulse too long");
  property p_flags;
    desc_valid |-> (desc.fragmented ? !(desc.first && desc.last) : !(desc.first || desc.last));
  endproperty
  a_flags: assert property (p_flags) else $error("bad flags");
  property p_seq;
    desc_valid && desc.fragmented |-> desc.seq == (desc.first ? 4'h0 : seq_q + 4'h1);
  endproperty
  a_seq: assert property (p_seq) else $error("bad sequence");
  property p_offset;
    desc_valid && desc.fragmented && !desc.first |-> desc.offset == end_q;
  endproperty
  a_offset: assert property (p_offset) else $error("remainder lost");
  property p_fill;
    desc_valid && desc.fragmented && !desc.last
      |-> desc.len == 16'($past(grant_in.slots, 2) * SLOT - POH - 16);
  endproperty
  a_fill: assert property (p_fill) else $error("grant not filled");
  property p_imm;
    desc_valid && $past(grant_in.immediate, 2) |-> !desc.fragmented;
  endproperty
  a_imm: assert property (p_imm) else $error("fragment in data region");
  property p_more;
    desc_valid && $past(grant_in.more, 2) |-> desc.piggy == 8'h0;
  endproperty
  a_more: assert property (p_more) else $error("piggyback with pending");
  property p_paylen;
    pay_valid && pay_ready && pay_last |-> cnt_q + 16'h1 == desc.len;
  endproperty
  a_paylen: assert property (p_paylen) else $error("payload length");
endmodule
bind umf_fragmenter umf_fragmenter_sva u_sva (
  .clk, .rst, .avs_read, .avs_write, .avs_waitrequest, .grant_in, .req_valid,
  .desc_valid, .desc, .pay_valid, .pay_last, .pay_ready
);
`default_nettype wire

/* verif/umf_headend.sv */
`timescale 1ns/1ps
`default_nettype none
module umf_headend
  import umf_pkg::*;
#(
  parameter int GAP = 3
)
(
  input wire logic clk,
  input wire logic rst,
  input wire logic req_valid,
  input wire logic [15:0] req_slots,
  input wire logic desc_valid,
  input wire umf_desc_type desc,
  input wire logic pay_done,
  input wire logic [15:0] max_slots,
  input wire logic multi,
  input wire logic imm,
  input wire logic mute,
  output umf_map_type map_in,
  output umf_grant_type grant_in
);
  logic [15:0] owed, give;
  int cnt;
  assign give = (owed > max_slots) ? max_slots : owed;
  // Grants come GAP cycles after a request or after a payload ends
  always @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      owed <= '0;
      cnt <= 0;
      map_in <= '0;
      grant_in <= '0;
    end
    else
    begin
      map_in <= '0;
      grant_in <= '0;
      cnt <= (req_valid || pay_done) ? 0 : cnt + 1;
      if (req_valid)
        owed <= req_slots;
      else if (desc_valid && (!multi || desc.last || !desc.fragmented))
        owed <= desc.piggy;
      else if (owed != 16'h0 && cnt == GAP && !mute)
      begin
        grant_in <= '{valid: 1'b1, slots: give, more: multi, immediate: imm};
        map_in <= '{valid: 1'b1, has_grant: 1'b1, has_pending: multi};
        if (!multi)
          owed <= '0;
      end
      else if (owed != 16'h0 && cnt == GAP)
        // Muted: a MAP that carries neither grant nor pending
        map_in <= '{valid: 1'b1, has_grant: 1'b0, has_pending: 1'b0};
    end
  end
endmodule
`default_nettype wire
